// [hdl/isd_defines.svh]
`ifndef ISD_DEFINES_SVH
`define ISD_DEFINES_SVH

// ----------------------------------------------------------------
// Opcode bytes and opcode field values
// ----------------------------------------------------------------
`define ISD_OP_BITPFX   8'hcb
`define ISD_OP_EXT      8'hed
`define ISD_OP_CALL     8'hcd
`define ISD_OP_CCF      8'h3f
`define ISD_OP_CP_IMM   8'hfe
`define ISD_OP_CP_IR    8'hbe
`define ISD_OP_CPL      8'h2f
`define ISD_OP_DAA      8'h27
`define ISD_OP_DEC_IR   8'h35
`define ISD_OP_BLK_DN   8'ha9
`define ISD_OP_BLK_UP   8'ha1
`define ISD_OP_BLK_DNR  8'hb9
`define ISD_OP_BLK_UPR  8'hb1
`define ISD_IDX_LOW     5'h1d
`define ISD_CP_R_HIGH   5'h17
`define ISD_COND_LOW    3'h4
`define ISD_DEC_LOW     3'h5
`define ISD_RSEL_MEM    3'h6
`define ISD_RSEL_ACC    3'h7

// ----------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------
`define ISD_F_S   7
`define ISD_F_Z   6
`define ISD_F_H   4
`define ISD_F_PV  2
`define ISD_F_N   1
`define ISD_F_C   0

// ----------------------------------------------------------------
// Clock counts
// ----------------------------------------------------------------
`define ISD_CLK_SHORT     20'h0_0002
`define ISD_CLK_BIT_R     20'h0_0004
`define ISD_CLK_BIT_M     20'h0_0008
`define ISD_CLK_BIT_M_PF  20'h0_0006
`define ISD_CLK_BIT_X     20'h0_000a
`define ISD_CLK_CALL      20'h0_000a
`define ISD_CLK_CALL_NT   20'h0_0006
`define ISD_CLK_CP_IMM    20'h0_0004
`define ISD_CLK_CP_M      20'h0_0006
`define ISD_CLK_CP_M_PF   20'h0_0004
`define ISD_CLK_CP_X      20'h0_000a
`define ISD_CLK_CP_X_PF   20'h0_0008
`define ISD_CLK_BLK       20'h0_000a
`define ISD_CLK_BLK_PF    20'h0_0008
`define ISD_CLK_RPT_BASE  20'h0_0008
`define ISD_CLK_RPT_STEP  20'h0_0004
`define ISD_CLK_DEC_M     20'h0_0008
`define ISD_CLK_DEC_M_PF  20'h0_0006
`define ISD_CLK_DEC_X     20'h0_000c
`define ISD_CLK_DEC_X_PF  20'h0_000a
`define ISD_CNT_RST       20'h0_0000

`endif

// [hdl/isd_pkg.sv]
package isd_pkg;

  typedef enum logic [3:0] {
    K_NONE, K_BITR, K_BITM, K_CALL, K_CCF, K_CP, K_CPM, K_BLK, K_CPL, K_DAA, K_DEC, K_DECM
  } isd_kind_e;

  typedef enum logic [1:0] {S_IDLE, S_RD, S_EXEC, S_WAIT} isd_state_e;

  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  f;
    logic [7:0]  b;
    logic [7:0]  c;
    logic [7:0]  d;
    logic [7:0]  e;
    logic [7:0]  h;
    logic [7:0]  l;
    logic [15:0] ix;
    logic [15:0] iy;
    logic [15:0] sp;
  } isd_regs_s;

  typedef struct packed {
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  b3;
    logic [15:0] pc;
    logic [15:0] pc_next;
  } isd_instr_s;

  typedef struct packed {
    logic        f_we;
    logic [7:0]  f;
    logic        r_we;
    logic [2:0]  r_sel;
    logic [7:0]  r_val;
    logic        hl_we;
    logic [15:0] hl;
    logic        bc_we;
    logic [15:0] bc;
    logic        sp_we;
    logic [15:0] sp;
    logic        pc_we;
    logic [15:0] pc;
  } isd_wb_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } isd_mem_s;

endpackage : isd_pkg

// [hdl/isd_core.sv]
// Contract
// - Bit test is CB then 01bbbrrr in 4 clocks; indexed form takes 10 clocks.
// - The bbb field picks bit 0 to 7 in plain binary.
// - Call pushes return address at SP-2, loads PC, 10 clocks, flags kept.
// - Conditional call acts only when condition holds; 10 taken, 6 not taken.
// - Condition field: NZ, Z, NC, C, PO, PE, P, M in order 000 to 111.
// - Carry complement inverts C, clears N, H gets old C, 2 clocks.
// - Build option makes carry complement clear H instead.
// - Compare subtracts without storing; N set, H and C borrows, S Z V follow.
// - Compare encodings and timing for register, immediate, pointer and indexed forms.
// - Down block compare reads at pointer, decrements pointer and count, 10 (8) clocks.
// - Block compare sets S Z H N from compare, PV if count non-zero, C kept.
// - Up block compare increments pointer, decrements count, PV flags non-zero count.
// - Repeating forms loop while count non-zero and no match; 8 + 4i clocks.
// - Interrupted repeat returns to the block compare's own address.
// - Pending interrupts are sampled during every memory read of a repeat.
// - Accumulator invert flips A, sets H and N, 2 clocks.
// - Decimal adjust sets S, Z, even parity on PV, keeps N, 2 clocks.
// - After addition, adjust adds 00/06/60/66; carry set when 60 or 66 added.
// - After subtraction, adjust adds 00/FA/A0/9A; carry unchanged.
// - Decrement subtracts one, N set, H borrow from bit 3, C kept.
// - Decrement timing: register 2, pointer 8 (6), indexed 12 (10) clocks.
// - Bit test sets Z when bit is zero, sets H, clears N.
// - Register field: B C D E H L, 111 accumulator.
// - Parenthesised clock counts apply when prefetch enable is high.
`timescale 1ns/1ps
`include "isd_defines.svh"
module isd_core #(
  parameter bit legacy_carry_complement_option = 1'b0
) (
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  input  wire logic                instr_valid,
  input  wire isd_pkg::isd_instr_s instr,
  input  wire isd_pkg::isd_regs_s  regs,
  input  wire logic                prefetch_en,
  input  wire logic                int_pending,
  input  wire logic                mem_rd_valid,
  input  wire logic [7:0]          mem_rd_data,
  output logic                     busy_q,
  output logic                     done_q,
  output logic                     illegal_q,
  output logic                     irq_take_q,
  output logic [15:0]              ret_pc_q,
  output isd_pkg::isd_wb_s         wb_q,
  output isd_pkg::isd_mem_s        mem_q
);
  import isd_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Returns {carry, half, overflow, result} of a - b
  function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] r;
    logic       v;
    r = {1'b0, a} - {1'b0, b};
    v = (a[7] != b[7]) && (r[7] != a[7]);
    return {r[8], (a[3:0] < b[3:0]), v, r[7:0]};
  endfunction : sub8

  function automatic logic [7:0] sel_reg(input isd_regs_s r, input logic [2:0] s);
    logic [7:0] v;
    case (s)
      3'h0:    v = r.b;
      3'h1:    v = r.c;
      3'h2:    v = r.d;
      3'h3:    v = r.e;
      3'h4:    v = r.h;
      3'h5:    v = r.l;
      3'h7:    v = r.a;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : sel_reg

  // Returns {carry after, half after, amount added}
  function automatic logic [9:0] daa_fn(input logic [7:0] a, input logic [7:0] f);
    logic       lo9;
    logic       lo_add;
    logic       hi_add;
    logic [7:0] adj;
    lo9    = a[3:0] > 4'h9;
    lo_add = f[`ISD_F_H] || lo9;
    hi_add = f[`ISD_F_C] || (a[7:4] > 4'h9) || ((a[7:4] >= 4'h9) && lo9);
    if (f[`ISD_F_N]) begin
      adj = {f[`ISD_F_C] ? (f[`ISD_F_H] ? 4'h9 : 4'ha) : (f[`ISD_F_H] ? 4'hf : 4'h0),
             f[`ISD_F_H] ? 4'ha : 4'h0};
      return {f[`ISD_F_C], f[`ISD_F_H] && (a[3:0] < 4'h6), adj};
    end
    adj = {hi_add ? 4'h6 : 4'h0, lo_add ? 4'h6 : 4'h0};
    return {hi_add, lo9, adj};
  endfunction : daa_fn

  // ----------------------------------------------------------------
  // Decode of the presented instruction
  // ----------------------------------------------------------------
  isd_state_e  st_q;
  isd_kind_e   k_d;
  isd_kind_e   kind_q;
  logic [7:0]  b0;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic [7:0]  b3;
  logic        idx_pfx;
  logic        cond_call;
  logic        blk_d;
  logic        cond_ok;
  logic        taken_d;
  logic [3:0]  cond_vec;
  logic [15:0] ea_d;
  logic [19:0] total_d;
  logic        start;
  logic        mem_kind_d;

  assign b0 = instr.b0;
  assign b1 = instr.b1;
  assign b2 = instr.b2;
  assign b3 = instr.b3;
  assign start     = (st_q == S_IDLE) && instr_valid;
  assign idx_pfx   = (b0[7:6] == 2'h3) && (b0[4:0] == `ISD_IDX_LOW);
  assign cond_call = (b0[7:6] == 2'h3) && (b0[2:0] == `ISD_COND_LOW);
  assign blk_d     = (b1 == `ISD_OP_BLK_DN) || (b1 == `ISD_OP_BLK_UP) ||
                     (b1 == `ISD_OP_BLK_DNR) || (b1 == `ISD_OP_BLK_UPR);
  // Flag pairs NZ/Z, NC/C, PO/PE, P/M; low bit of field picks the polarity
  assign cond_vec  = {regs.f[`ISD_F_S], regs.f[`ISD_F_PV], regs.f[`ISD_F_C], regs.f[`ISD_F_Z]};
  assign cond_ok   = cond_vec[b0[5:4]] == b0[3];
  assign taken_d   = (b0 == `ISD_OP_CALL) || cond_ok;

  assign k_d =
    (b0 == `ISD_OP_BITPFX) ? ((b1[7:6] != 2'h1) ? K_NONE :
                              (b1[2:0] == `ISD_RSEL_MEM) ? K_BITM : K_BITR) :
    idx_pfx ? (((b1 == `ISD_OP_BITPFX) && (b3[7:6] == 2'h1) &&
                (b3[2:0] == `ISD_RSEL_MEM)) ? K_BITM :
               (b1 == `ISD_OP_CP_IR) ? K_CPM :
               (b1 == `ISD_OP_DEC_IR) ? K_DECM : K_NONE) :
    ((b0 == `ISD_OP_CALL) || cond_call) ? K_CALL :
    (b0 == `ISD_OP_CCF) ? K_CCF :
    (b0[7:3] == `ISD_CP_R_HIGH) ? ((b0[2:0] == `ISD_RSEL_MEM) ? K_CPM : K_CP) :
    (b0 == `ISD_OP_CP_IMM) ? K_CP :
    ((b0 == `ISD_OP_EXT) && blk_d) ? K_BLK :
    (b0 == `ISD_OP_CPL) ? K_CPL :
    (b0 == `ISD_OP_DAA) ? K_DAA :
    ((b0[7:6] == 2'h0) && (b0[2:0] == `ISD_DEC_LOW)) ?
      ((b0[5:3] == `ISD_RSEL_MEM) ? K_DECM : K_DEC) : K_NONE;

  assign mem_kind_d = (k_d == K_BITM) || (k_d == K_CPM) || (k_d == K_DECM) || (k_d == K_BLK);
  assign ea_d = idx_pfx ? ((b0[5] ? regs.iy : regs.ix) + {{8{b2[7]}}, b2}) :
                {regs.h, regs.l};

  // Prefetch shortens only the forms that have address calculation time
  assign total_d =
    (k_d == K_BITR) ? `ISD_CLK_BIT_R :
    (k_d == K_BITM) ? (idx_pfx ? `ISD_CLK_BIT_X :
                       prefetch_en ? `ISD_CLK_BIT_M_PF : `ISD_CLK_BIT_M) :
    (k_d == K_CALL) ? (taken_d ? `ISD_CLK_CALL : `ISD_CLK_CALL_NT) :
    (k_d == K_CP) ? ((b0 == `ISD_OP_CP_IMM) ? `ISD_CLK_CP_IMM : `ISD_CLK_SHORT) :
    (k_d == K_CPM) ? (idx_pfx ? (prefetch_en ? `ISD_CLK_CP_X_PF : `ISD_CLK_CP_X) :
                      (prefetch_en ? `ISD_CLK_CP_M_PF : `ISD_CLK_CP_M)) :
    (k_d == K_BLK) ? (b1[4] ? (`ISD_CLK_RPT_BASE + `ISD_CLK_RPT_STEP) :
                      (prefetch_en ? `ISD_CLK_BLK_PF : `ISD_CLK_BLK)) :
    (k_d == K_DECM) ? (idx_pfx ? (prefetch_en ? `ISD_CLK_DEC_X_PF : `ISD_CLK_DEC_X) :
                       (prefetch_en ? `ISD_CLK_DEC_M_PF : `ISD_CLK_DEC_M)) :
    `ISD_CLK_SHORT;

  // ----------------------------------------------------------------
  // Execution datapath
  // ----------------------------------------------------------------
  isd_instr_s  ins_q;
  isd_regs_s   rg_q;
  logic [7:0]  md_q;
  logic [15:0] ptr_q;
  logic [15:0] bc_q;
  logic        taken_q;
  logic        int_seen_q;
  logic        irq_q;
  logic [19:0] cnt_q;
  logic [19:0] total_q;
  logic [2:0]  bitsel;
  logic [2:0]  rsel;
  logic        mem_kind;
  logic [7:0]  opnd;
  logic [10:0] cmp;
  logic [10:0] dcr;
  logic [9:0]  daa;
  logic [7:0]  daa_res;
  logic [15:0] bc_dec;
  logic [15:0] ptr_nx;
  logic        rpt_more;
  logic        fin;
  logic [7:0]  f_n;
  isd_wb_s     wb_d;

  assign mem_kind = (kind_q == K_BITM) || (kind_q == K_CPM) ||
                    (kind_q == K_DECM) || (kind_q == K_BLK);
  assign bitsel   = (ins_q.b0 == `ISD_OP_BITPFX) ? ins_q.b1[5:3] : ins_q.b3[5:3];
  assign rsel     = (kind_q == K_BITR) ? ins_q.b1[2:0] :
                    (kind_q == K_DEC) ? ins_q.b0[5:3] : ins_q.b0[2:0];
  assign opnd     = mem_kind ? md_q :
                    (ins_q.b0 == `ISD_OP_CP_IMM) ? ins_q.b1 : sel_reg(rg_q, rsel);
  assign cmp      = sub8(rg_q.a, opnd);
  assign dcr      = sub8(opnd, 8'h01);
  assign daa      = daa_fn(rg_q.a, rg_q.f);
  assign daa_res  = rg_q.a + daa[7:0];
  assign bc_dec   = bc_q - 16'h0001;
  assign ptr_nx   = ins_q.b1[3] ? (ptr_q - 16'h0001) : (ptr_q + 16'h0001);
  // Repeat stops on count exhausted or a match
  assign rpt_more = (kind_q == K_BLK) && ins_q.b1[4] && (bc_dec != 16'h0000) &&
                    (cmp[7:0] != 8'h00);
  assign fin      = cnt_q >= (total_q - 20'h0_0001);

  always_comb begin
    wb_d = '0;
    f_n  = rg_q.f;
    case (kind_q)
      K_BITR, K_BITM: begin
        f_n[`ISD_F_Z] = ~opnd[bitsel];
        f_n[`ISD_F_H] = 1'b1;
        f_n[`ISD_F_N] = 1'b0;
        wb_d.f_we     = 1'b1;
      end
      K_CALL: begin
        wb_d.sp_we = taken_q;
        wb_d.sp    = rg_q.sp - 16'h0002;
        wb_d.pc_we = taken_q;
        wb_d.pc    = {ins_q.b2, ins_q.b1};
      end
      K_CCF: begin
        f_n[`ISD_F_C] = ~rg_q.f[`ISD_F_C];
        f_n[`ISD_F_N] = 1'b0;
        f_n[`ISD_F_H] = legacy_carry_complement_option ? 1'b0 : rg_q.f[`ISD_F_C];
        wb_d.f_we     = 1'b1;
      end
      K_CP, K_CPM: begin
        f_n = {cmp[7], cmp[7:0] == 8'h00, rg_q.f[5], cmp[9], rg_q.f[3], cmp[8], 1'b1,
               cmp[10]};
        wb_d.f_we = 1'b1;
      end
      K_BLK: begin
        f_n = {cmp[7], cmp[7:0] == 8'h00, rg_q.f[5], cmp[9], rg_q.f[3],
               bc_dec != 16'h0000, 1'b1, rg_q.f[`ISD_F_C]};
        wb_d.f_we  = 1'b1;
        wb_d.hl_we = 1'b1;
        wb_d.hl    = ptr_nx;
        wb_d.bc_we = 1'b1;
        wb_d.bc    = bc_dec;
      end
      K_CPL: begin
        f_n[`ISD_F_H] = 1'b1;
        f_n[`ISD_F_N] = 1'b1;
        wb_d.f_we     = 1'b1;
        wb_d.r_we     = 1'b1;
        wb_d.r_sel    = `ISD_RSEL_ACC;
        wb_d.r_val    = ~rg_q.a;
      end
      K_DAA: begin
        f_n = {daa_res[7], daa_res == 8'h00, rg_q.f[5], daa[8], rg_q.f[3], ~^daa_res,
               rg_q.f[`ISD_F_N], daa[9]};
        wb_d.f_we  = 1'b1;
        wb_d.r_we  = 1'b1;
        wb_d.r_sel = `ISD_RSEL_ACC;
        wb_d.r_val = daa_res;
      end
      K_DEC, K_DECM: begin
        f_n = {dcr[7], dcr[7:0] == 8'h00, rg_q.f[5], dcr[9], rg_q.f[3], dcr[8], 1'b1,
               rg_q.f[`ISD_F_C]};
        wb_d.f_we  = 1'b1;
        wb_d.r_we  = (kind_q == K_DEC);
        wb_d.r_sel = rsel;
        wb_d.r_val = dcr[7:0];
      end
      default: ;
    endcase
    wb_d.f = f_n;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_q <= S_IDLE; kind_q <= K_NONE; ins_q <= '0; rg_q <= '0; md_q <= 8'h00;
      ptr_q <= 16'h0000; bc_q <= 16'h0000; taken_q <= 1'b0; int_seen_q <= 1'b0;
      irq_q <= 1'b0; cnt_q <= `ISD_CNT_RST; total_q <= `ISD_CNT_RST; busy_q <= 1'b0;
      done_q <= 1'b0; illegal_q <= 1'b0; irq_take_q <= 1'b0; ret_pc_q <= 16'h0000;
      wb_q <= '0; mem_q <= '0;
    end else begin
      done_q     <= 1'b0;
      illegal_q  <= 1'b0;
      irq_take_q <= 1'b0;
      wb_q       <= '0;
      mem_q.rd   <= 1'b0;
      mem_q.wr   <= 1'b0;
      cnt_q      <= cnt_q + 20'h0_0001;
      case (st_q)
        S_IDLE: if (start) begin
          ins_q <= instr; rg_q <= regs; kind_q <= k_d; taken_q <= taken_d;
          ptr_q <= ea_d; bc_q <= {regs.b, regs.c}; total_q <= total_d;
          cnt_q <= 20'h0_0001; irq_q <= 1'b0; ret_pc_q <= instr.pc;
          if (k_d == K_NONE) begin
            illegal_q <= 1'b1;
            done_q    <= 1'b1;
          end else begin
            busy_q     <= 1'b1;
            st_q       <= mem_kind_d ? S_RD : S_EXEC;
            mem_q.rd   <= mem_kind_d;
            mem_q.addr <= ea_d;
          end
        end
        S_RD: if (mem_rd_valid) begin
          md_q       <= mem_rd_data;
          int_seen_q <= int_pending;
          st_q       <= S_EXEC;
        end
        S_EXEC: begin
          wb_q <= wb_d;
          if ((kind_q == K_CALL) && taken_q) begin
            mem_q <= '{rd: 1'b0, wr: 1'b1, word: 1'b1, addr: rg_q.sp - 16'h0002,
                       wdata: ins_q.pc_next};
          end
          if (kind_q == K_DECM) begin
            mem_q <= '{rd: 1'b0, wr: 1'b1, word: 1'b0, addr: ptr_q, wdata: {8'h00, dcr[7:0]}};
          end
          if (kind_q == K_BLK) begin
            ptr_q <= ptr_nx;
            bc_q  <= bc_dec;
          end
          if (rpt_more && !int_seen_q) begin
            total_q    <= total_q + `ISD_CLK_RPT_STEP;
            st_q       <= S_RD;
            mem_q.rd   <= 1'b1;
            mem_q.addr <= ptr_nx;
          end else begin
            irq_q <= rpt_more;
            if (fin) begin
              done_q     <= 1'b1;
              irq_take_q <= rpt_more;
              busy_q     <= 1'b0;
              st_q       <= S_IDLE;
            end else begin
              st_q <= S_WAIT;
            end
          end
        end
        S_WAIT: if (fin) begin
          done_q     <= 1'b1;
          irq_take_q <= irq_q;
          busy_q     <= 1'b0;
          st_q       <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // done_q of the previous instruction may still stand in the accepting cycle
  bit_reg_time_a: assert property (start && k_d == K_BITR |-> ##1 !done_q [*3] ##1 done_q)
    else $error("bit test register form not 4 clocks");
  call_time_a: assert property (start && k_d == K_CALL && taken_d |-> ##10 done_q)
    else $error("taken call not 10 clocks");
  call_skip_a: assert property (start && k_d == K_CALL && !taken_d |-> ##6 done_q)
    else $error("untaken call not 6 clocks");
  call_push_a: assert property (wb_q.sp_we |-> wb_q.sp == rg_q.sp - 16'h0002 && mem_q.wr
                                && mem_q.addr == wb_q.sp && taken_q)
    else $error("call push address wrong");
  cond_pick_a: assert property (start && k_d == K_CALL && b0[5:3] == 3'h1
                                && b0 != `ISD_OP_CALL |-> taken_d == regs.f[`ISD_F_Z])
    else $error("zero-set condition misdecoded");
  ccf_flags_a: assert property (wb_q.f_we && kind_q == K_CCF |->
                                wb_q.f[`ISD_F_C] != rg_q.f[`ISD_F_C] && !wb_q.f[`ISD_F_N] &&
                                wb_q.f[`ISD_F_H] == (!legacy_carry_complement_option &&
                                rg_q.f[`ISD_F_C]))
    else $error("carry complement flags wrong");
  cmp_flags_a: assert property (wb_q.f_we && kind_q == K_CP |-> wb_q.f[`ISD_F_N] &&
                                wb_q.f[`ISD_F_C] == (rg_q.a < opnd) && !wb_q.r_we)
    else $error("compare flags or store wrong");
  blk_flags_a: assert property (wb_q.f_we && kind_q == K_BLK |->
                                wb_q.f[`ISD_F_PV] == (wb_q.bc != 16'h0000) &&
                                wb_q.f[`ISD_F_C] == rg_q.f[`ISD_F_C])
    else $error("block compare flags wrong");
  blk_ptr_a: assert property (wb_q.hl_we |-> wb_q.hl == (ins_q.b1[3] ? $past(ptr_q) - 16'h0001
                              : $past(ptr_q) + 16'h0001))
    else $error("block pointer step wrong");
  irq_ret_a: assert property (irq_take_q |-> done_q && ret_pc_q == ins_q.pc)
    else $error("interrupted repeat return address wrong");
  cpl_value_a: assert property (start && k_d == K_CPL |-> ##2 (wb_q.r_val == ~rg_q.a
                                && wb_q.r_we && done_q))
    else $error("accumulator invert wrong");
  daa_sub_a: assert property (wb_q.f_we && kind_q == K_DAA && rg_q.f[`ISD_F_N] |->
                              wb_q.f[`ISD_F_C] == rg_q.f[`ISD_F_C] && wb_q.f[`ISD_F_N])
    else $error("decimal adjust after subtract wrong");
  dec_flags_a: assert property (wb_q.f_we && kind_q == K_DEC |-> wb_q.f[`ISD_F_N] &&
                                wb_q.f[`ISD_F_C] == rg_q.f[`ISD_F_C])
    else $error("decrement flags wrong");

  rpt_loop_c: cover property (wb_q.hl_we && rpt_more ##[1:8] wb_q.hl_we);
  irq_stop_c: cover property (irq_take_q);
  call_taken_c: cover property (mem_q.wr && mem_q.word);
  daa_add_c: cover property (wb_q.f_we && kind_q == K_DAA && wb_q.f[`ISD_F_C]);

endmodule : isd_core

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import isd_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic        ref_clk      = 1'b0;
  logic        rstn         = 1'b0;
  logic        instr_valid  = 1'b0;
  logic        prefetch_en  = 1'b0;
  logic        int_pending  = 1'b0;
  logic        mem_rd_valid = 1'b0;
  logic [7:0]  mem_rd_data  = 8'h00;
  isd_instr_s  ins          = '0;
  isd_regs_s   rg           = '0;
  logic        busy_q, done_q, illegal_q, irq_take_q, irq_s;
  logic [15:0] ret_pc_q;
  isd_wb_s     wb_q;
  isd_mem_s    mem_q;
  logic [15:0] f_s, r_s, pc_s, sp_s, hl_s, bc_s, ma_s, md_s;
  int          num_errors   = 0;
  int          comparisons  = 0;
  int          pos[4]       = '{6, 0, 2, 7};

  always #5 ref_clk = ~ref_clk;

  isd_core i_isd_core (.ref_clk(ref_clk), .rstn(rstn), .instr_valid(instr_valid),
    .instr(ins), .regs(rg), .prefetch_en(prefetch_en), .int_pending(int_pending),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .busy_q(busy_q),
    .done_q(done_q), .illegal_q(illegal_q), .irq_take_q(irq_take_q),
    .ret_pc_q(ret_pc_q), .wb_q(wb_q), .mem_q(mem_q));

  // Memory answers one cycle after each read strobe, the slowest that keeps timing
  always @(posedge ref_clk) begin
    mem_rd_valid <= #1 mem_q.rd;
    if (wb_q.f_we) f_s <= {8'h00, wb_q.f};
    if (wb_q.r_we) r_s <= {8'h00, wb_q.r_val};
    if (wb_q.pc_we) pc_s <= wb_q.pc;
    if (wb_q.sp_we) sp_s <= wb_q.sp;
    if (wb_q.hl_we) hl_s <= wb_q.hl;
    if (wb_q.bc_we) bc_s <= wb_q.bc;
    if (mem_q.wr) ma_s <= mem_q.addr;
    if (mem_q.wr) md_s <= mem_q.wdata;
    if (done_q) irq_s <= irq_take_q;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Cycle count runs from the accepting cycle to the done pulse
  task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                     input logic [15:0] n);
    logic [15:0] c;
    {f_s, r_s, pc_s, sp_s, hl_s, bc_s, ma_s, md_s} = 'x;
    ins.b0 = b0;
    ins.b1 = b1;
    ins.b2 = b2;
    instr_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    instr_valid = 1'b0;
    c = 16'h0001;
    while (done_q !== 1'b1 && c < 16'h00c8) begin
      @(posedge ref_clk);
      #1;
      c++;
    end
    // Let the capture process see the last write-back and the done pulse
    @(posedge ref_clk);
    #1;
    check(c, n);
  endtask : run

  task automatic end_sim;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  initial begin
    #100000;
    num_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    rg.sp = 16'h1000;
    ins.pc = 16'h0100;
    ins.pc_next = 16'habcd;
    run(8'hcd, 8'h34, 8'h12, 16'h000a);
    check(sp_s, 16'h0ffe);
    check(pc_s, 16'h1234);
    check(ma_s, 16'h0ffe);
    check(md_s, 16'habcd);
    for (int k = 0; k < 16; k++) begin
      rg.f = 8'h00;
      rg.f[pos[k[2:1]]] = ~(k[3] ^ k[0]);
      run({2'b11, k[2:0], 3'b100}, 8'h78, 8'h56, k[3] ? 16'h000a : 16'h0006);
      check(pc_s, k[3] ? 16'h5678 : 16'hxxxx);
    end
    rg.f = 8'hc5;
    run(8'h3f, 8'h00, 8'h00, 16'h0002);
    check(f_s, 16'h00d4);
    rg.a = 8'h5a;
    run(8'h2f, 8'h00, 8'h00, 16'h0002);
    check(r_s, 16'h00a5);
    check(f_s, 16'h00d7);
    rg.a = 8'h9a;
    rg.f = 8'h00;
    run(8'h27, 8'h00, 8'h00, 16'h0002);
    check(r_s, 16'h0000);
    check(f_s, 16'h0055);
    rg.a = 8'h85;
    rg.f = 8'h03;
    run(8'h27, 8'h00, 8'h00, 16'h0002);
    check(r_s, 16'h0025);
    check(f_s, 16'h0003);
    rg.a = 8'h10;
    rg.b = 8'h20;
    rg.f = 8'h00;
    run(8'hb8, 8'h00, 8'h00, 16'h0002);
    check(f_s, 16'h0083);
    check(r_s, 16'hxxxx);
    rg.b = 8'h10;
    rg.f = 8'h01;
    run(8'h05, 8'h00, 8'h00, 16'h0002);
    check(r_s, 16'h000f);
    check(f_s, 16'h0013);
    rg.a = 8'h7f;
    run(8'hcb, 8'h7f, 8'h00, 16'h0004);
    check(f_s, 16'h0051);
    run(8'hcb, 8'h77, 8'h00, 16'h0004);
    check(f_s, 16'h0011);
    rg.a = 8'h55;
    {rg.h, rg.l, rg.b, rg.c} = 32'h2000_0003;
    run(8'hed, 8'hb1, 8'h00, 16'h0014);
    check(hl_s, 16'h2003);
    check(bc_s, 16'h0000);
    check(f_s, 16'h0003);
    prefetch_en = 1'b1;
    run(8'hed, 8'ha9, 8'h00, 16'h0008);
    check(hl_s, 16'h1fff);
    check(f_s, 16'h0007);
    prefetch_en = 1'b0;
    int_pending = 1'b1;
    run(8'hed, 8'hb9, 8'h00, 16'h000c);
    check({15'h0000, irq_s}, 16'h0001);
    check(ret_pc_q, 16'h0100);
    check(bc_s, 16'h0002);
    int_pending = 1'b0;
    end_sim();
  end
endmodule : testbench
